// [rx_buf_pkg.sv]
// shared constants and types for the receive buffer control block
package rx_buf_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int LIM_W = 6;
  localparam int CNT_W = 5;
  localparam int PTR_W = 4;
  localparam int TICK_W = 8;
  localparam int BUF_DEPTH = 16;
  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] CTRL1_IDX = 4'h1;
  localparam logic [ADDR_W-1:0] CTRL4_IDX = 4'h4;
  localparam logic [ADDR_W-1:0] CTRL5_IDX = 4'h5;
  localparam logic [ADDR_W-1:0] CTRL6_IDX = 4'h6;
  localparam logic [ADDR_W-1:0] CTRL7_IDX = 4'h7;
  localparam logic [ADDR_W-1:0] STAT_IDX = 4'h8;
  localparam logic [ADDR_W-1:0] FIFO_IDX = 4'h9;
  // control register 1 and status register field positions
  localparam int OP_A_BIT = 0;
  localparam int OP_B_BIT = 1;
  localparam int OP_C_BIT = 2;
  localparam int TRANSP_BIT = 3;
  localparam int IRQ_LO_BIT = 4;
  localparam int IRQ_HI_BIT = 5;
  localparam int STAT_ACTIVE_BIT = 7;
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  // fill levels picked by the two interrupt-level bits
  localparam logic [CNT_W-1:0] IRQ_LVL0 = 5'h01;
  localparam logic [CNT_W-1:0] IRQ_LVL1 = 5'h04;
  localparam logic [CNT_W-1:0] IRQ_LVL2 = 5'h08;
  localparam logic [CNT_W-1:0] IRQ_LVL3 = 5'h0C;

  typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA} rxState_t;

  function automatic logic [CNT_W-1:0] irqLevel(input logic [1:0] sel);
    unique case (sel)
      2'h0: irqLevel = IRQ_LVL0;
      2'h1: irqLevel = IRQ_LVL1;
      2'h2: irqLevel = IRQ_LVL2;
      2'h3: irqLevel = IRQ_LVL3;
    endcase
  endfunction

  // registers whose write resets an active reception
  function automatic logic isCtrlIdx(input logic [ADDR_W-1:0] a);
    isCtrlIdx = (a == CTRL1_IDX) || (a == CTRL4_IDX) || (a == CTRL5_IDX) ||
                (a == CTRL6_IDX) || (a == CTRL7_IDX);
  endfunction
endpackage

// [rx_byte_mem.sv]
// sixteen-byte receive store with registered read port
`timescale 1ns/1ns
`default_nettype none
module rx_byte_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic mclk, // system clock
  input wire logic we, // write one byte
  input wire logic [AW-1:0] waddr, // write slot
  input wire logic [DW-1:0] wdata, // byte to store
  input wire logic [AW-1:0] raddr, // slot to present next cycle
  output logic [DW-1:0] rdata // registered read data
);
  logic [DW-1:0] mem [DEPTH];

  // bypass keeps a byte written into the slot being read visible at once
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (we && (waddr == raddr))
    begin
      rdata <= wdata;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// [edge_gap_classifier.sv]
// measures edge-to-edge gaps and sorts them into single, double or bad
`timescale 1ns/1ns
`default_nettype none
module edge_gap_classifier #(
  parameter int TICK_DIV = 8 // mclk cycles per edge counter period
) (
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic run, // measuring enabled
  input wire logic lvl, // synchronised demodulated level
  input wire logic [rx_buf_pkg::LIM_W-1:0] limMin, // single-gap lower limit
  input wire logic [rx_buf_pkg::LIM_W-1:0] limMax, // single-gap upper limit
  output logic edgeSeen, // pulse: an edge was measured
  output logic edgeRise, // the edge was low-to-high
  output logic isSingle, // gap fits the T window
  output logic isDouble, // gap fits the 2T window
  output logic timeout // pulse: no edge before 2T upper bound
);
  localparam int DIV_W = $clog2(TICK_DIV + 1);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [rx_buf_pkg::TICK_W-1:0] cnt;
    logic prev;
    logic edgeSeen;
    logic edgeRise;
    logic isSingle;
    logic isDouble;
    logic timeout;
  } gapState_t;

  gapState_t q, d;
  logic [rx_buf_pkg::TICK_W-1:0] sum, lo2, hi2, minW, maxW;
  logic [rx_buf_pkg::LIM_W-1:0] span;
  logic [rx_buf_pkg::LIM_W:0] spanUp;

  // --------------------------------------------------------------
  // double-gap window, bounds rounded up
  // --------------------------------------------------------------
  always_comb
  begin
    minW = {2'h0, limMin};
    maxW = {2'h0, limMax};
    sum = minW + maxW;
    span = limMax - limMin;
    spanUp = {1'b0, span} + 7'h01;
    lo2 = sum - {3'h0, span[rx_buf_pkg::LIM_W-1:1]};
    hi2 = sum + {2'h0, spanUp[rx_buf_pkg::LIM_W:1]};
  end

  // --------------------------------------------------------------
  // tick counter and classification
  // --------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.edgeSeen = 1'b0;
    d.timeout = 1'b0;
    d.prev = lvl;
    if (!run)
    begin
      d.div = '0;
      d.cnt = '0;
    end
    else if (lvl != q.prev)
    begin
      d.edgeSeen = 1'b1;
      d.edgeRise = lvl;
      d.isSingle = (q.cnt >= minW) && (q.cnt < maxW);
      d.isDouble = (q.cnt >= lo2) && (q.cnt < hi2);
      d.div = '0;
      d.cnt = '0;
    end
    else if (q.div == DIV_W'(TICK_DIV - 1))
    begin
      d.div = '0;
      // saturate so a dead line cannot wrap back into a window
      if (q.cnt != '1)
      begin
        d.cnt = q.cnt + 8'h01;
      end
      d.timeout = (d.cnt == hi2) && (q.cnt != hi2);
    end
    else
    begin
      d.div = q.div + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign edgeSeen = q.edgeSeen;
  assign edgeRise = q.edgeRise;
  assign isSingle = q.isSingle;
  assign isDouble = q.isDouble;
  assign timeout = q.timeout;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_SINGLE_WINDOW: assert property (@(posedge mclk) disable iff (rst)
    run && $past(run) && (lvl != q.prev) |=> isSingle ==
    (($past(q.cnt) >= {2'h0, $past(limMin)}) && ($past(q.cnt) < {2'h0, $past(limMax)})))
    else $error("single-gap window misjudged");
  AST_NO_SPURIOUS_EDGE: assert property (@(posedge mclk) disable iff (rst)
    !run |=> !edgeSeen && !timeout)
    else $error("gap event while idle");
endmodule
`default_nettype wire

// [rx_buffer_ctrl.sv]
// receive data buffer control: Manchester decode, byte store and fill counter
//   Operation
// - after a good bit-check, enter receiving mode and evaluate the stream.
// - only single T and double 2T edge gaps are valid.
// - the T window uses the bit-check limits from control registers 5 and 6.
// - 2T bounds are sum of limits minus or plus half their span.
// - fractional 2T bounds round up to the next integer.
// - after the start bit, store bytes; start bit belongs to first byte.
// - sixteen-byte buffer; longer messages overwrite held bytes without stalling.
// - byte counter rises per stored byte, falls per read, and is readable.
// - interrupt when the rising counter reaches the selected level.
// - a bit error raises an interrupt and returns to start-up.
// - a gap outside both windows is a timing bit error.
// - a missing mid-cell edge is a logical bit error.
// - a byte holding a bit error is never stored.
// - writing control register 1, 4, 5, 6 or 7 while receiving resets all.
// - if mode bits still say receive after that, restart signal-processing start-up.
// - low-to-high decodes as 1, high-to-low as 0.
// - T window is lower limit to upper limit minus one counter periods.
// - buffer only when transparent mode is off; Manchester and bi-phase only.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module rx_buffer_ctrl #(
  parameter int TICK_DIV = 8 // mclk cycles per edge counter period
) (
  input wire logic mclk, // 125 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [rx_buf_pkg::ADDR_W-1:0] regAddr, // register index
  input wire logic [rx_buf_pkg::DATA_W-1:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [rx_buf_pkg::DATA_W-1:0] regRdata, // read data, cycle after strobe
  input wire logic demodIn, // demodulated stream pin
  input wire logic bitCheckDone, // pulse: bit-check succeeded
  output logic irqOut, // pulse: fill level or bit error
  output logic rxActive, // receiving mode
  output logic restartSigProc // pulse: re-enter signal-processing start-up
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    rx_buf_pkg::rxState_t mode;
    logic center;
    logic [2:0] bitCnt;
    logic [rx_buf_pkg::DATA_W-1:0] shift;
    logic [rx_buf_pkg::PTR_W-1:0] wptr;
    logic [rx_buf_pkg::PTR_W-1:0] rptr;
    logic [rx_buf_pkg::CNT_W-1:0] count;
    logic [rx_buf_pkg::DATA_W-1:0] ctrl1;
    logic [rx_buf_pkg::DATA_W-1:0] ctrl4;
    logic [rx_buf_pkg::DATA_W-1:0] ctrl5;
    logic [rx_buf_pkg::DATA_W-1:0] ctrl6;
    logic [rx_buf_pkg::DATA_W-1:0] ctrl7;
    logic [rx_buf_pkg::DATA_W-1:0] rdata;
    logic irq;
    logic restart;
    logic active;
  } ctrlState_t;

  ctrlState_t q, d;
  logic edgeSeen, edgeRise, isSingle, isDouble, timeout;
  logic [rx_buf_pkg::DATA_W-1:0] memQ;
  logic [rx_buf_pkg::DATA_W-1:0] newByte;
  logic push, pop, bitErr, ctrlWrite, restartCond, storeBit;

  // --------------------------------------------------------------
  // gap measurement and byte store
  // --------------------------------------------------------------
  edge_gap_classifier #(.TICK_DIV(TICK_DIV)) gapUnit (
    .mclk(mclk),
    .rst(rst),
    .run(q.mode != rx_buf_pkg::RX_IDLE),
    .lvl(q.sync2),
    .limMin(q.ctrl5[rx_buf_pkg::LIM_W-1:0]),
    .limMax(q.ctrl6[rx_buf_pkg::LIM_W-1:0]),
    .edgeSeen(edgeSeen),
    .edgeRise(edgeRise),
    .isSingle(isSingle),
    .isDouble(isDouble),
    .timeout(timeout)
  );

  rx_byte_mem #(.DEPTH(rx_buf_pkg::BUF_DEPTH), .AW(rx_buf_pkg::PTR_W), .DW(rx_buf_pkg::DATA_W)) store (
    .mclk(mclk),
    .we(push),
    .waddr(q.wptr),
    .wdata(newByte),
    .raddr(d.rptr),
    .rdata(memQ)
  );

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.irq = 1'b0;
    d.restart = 1'b0;
    d.rdata = '0;
    d.sync1 = demodIn;
    d.sync2 = q.sync1;
    push = 1'b0;
    bitErr = 1'b0;
    storeBit = 1'b0;
    newByte = {q.shift[rx_buf_pkg::DATA_W-2:0], edgeRise};
    ctrlWrite = regWr && rx_buf_pkg::isCtrlIdx(regAddr);
    pop = regRd && (regAddr == rx_buf_pkg::FIFO_IDX) && (q.count != '0);

    // register writes
    if (regWr)
    begin
      unique case (regAddr)
        rx_buf_pkg::CTRL1_IDX: d.ctrl1 = regWdata;
        rx_buf_pkg::CTRL4_IDX: d.ctrl4 = regWdata;
        rx_buf_pkg::CTRL5_IDX: d.ctrl5 = regWdata;
        rx_buf_pkg::CTRL6_IDX: d.ctrl6 = regWdata;
        rx_buf_pkg::CTRL7_IDX: d.ctrl7 = regWdata;
        default: ;
      endcase
    end

    // register reads, data valid the cycle after the strobe
    if (regRd)
    begin
      unique case (regAddr)
        rx_buf_pkg::CTRL1_IDX: d.rdata = q.ctrl1;
        rx_buf_pkg::CTRL4_IDX: d.rdata = q.ctrl4;
        rx_buf_pkg::CTRL5_IDX: d.rdata = q.ctrl5;
        rx_buf_pkg::CTRL6_IDX: d.rdata = q.ctrl6;
        rx_buf_pkg::CTRL7_IDX: d.rdata = q.ctrl7;
        rx_buf_pkg::STAT_IDX: d.rdata = {q.mode != rx_buf_pkg::RX_IDLE, 2'h0, q.count};
        rx_buf_pkg::FIFO_IDX: d.rdata = pop ? memQ : '0;
        default: d.rdata = '0;
      endcase
    end

    // decoder: center marks that the last edge sat mid-cell
    unique case (q.mode)
      rx_buf_pkg::RX_IDLE:
      begin
        if (bitCheckDone && !q.ctrl1[rx_buf_pkg::TRANSP_BIT])
        begin
          d.mode = rx_buf_pkg::RX_HUNT;
          d.bitCnt = '0;
        end
      end
      rx_buf_pkg::RX_HUNT:
      begin
        // preburst gives only single gaps; the first double gap ends on the start bit
        if (timeout || (edgeSeen && !isSingle && !isDouble))
        begin
          bitErr = 1'b1;
        end
        else if (edgeSeen && isDouble)
        begin
          d.mode = rx_buf_pkg::RX_DATA;
          storeBit = 1'b1;
        end
      end
      rx_buf_pkg::RX_DATA:
      begin
        if (timeout || (edgeSeen && !isSingle && !isDouble))
        begin
          bitErr = 1'b1;
        end
        else if (edgeSeen && isDouble && !q.center)
        begin
          bitErr = 1'b1;
        end
        else if (edgeSeen && isSingle && q.center)
        begin
          d.center = 1'b0;
        end
        else if (edgeSeen)
        begin
          storeBit = 1'b1;
        end
      end
      default: bitErr = 1'b1;
    endcase

    // shift in a decoded bit, push on the eighth
    if (storeBit)
    begin
      d.center = 1'b1;
      d.shift = newByte;
      d.bitCnt = q.bitCnt + rx_buf_pkg::BIT_ONE;
      if (q.bitCnt == rx_buf_pkg::LAST_BIT_IDX)
      begin
        push = 1'b1;
      end
    end

    // an error drops the partial byte and leaves receiving mode
    if (bitErr)
    begin
      d.mode = rx_buf_pkg::RX_IDLE;
      d.bitCnt = '0;
      d.center = 1'b0;
      d.irq = 1'b1;
    end

    // fill counter and pointers; full writes overwrite the oldest byte
    if (push)
    begin
      d.wptr = q.wptr + rx_buf_pkg::PTR_ONE;
    end
    if (pop || (push && (q.count == rx_buf_pkg::CNT_FULL)))
    begin
      d.rptr = q.rptr + rx_buf_pkg::PTR_ONE;
    end
    if (push && !pop && (q.count != rx_buf_pkg::CNT_FULL))
    begin
      d.count = q.count + rx_buf_pkg::CNT_ONE;
      if (d.count == rx_buf_pkg::irqLevel({q.ctrl1[rx_buf_pkg::IRQ_HI_BIT], q.ctrl1[rx_buf_pkg::IRQ_LO_BIT]}))
      begin
        d.irq = 1'b1;
      end
    end
    else if (pop && !push)
    begin
      d.count = q.count - rx_buf_pkg::CNT_ONE;
    end

    // reconfiguration while receiving wipes the buffer state
    restartCond = d.ctrl1[rx_buf_pkg::OP_A_BIT] && d.ctrl1[rx_buf_pkg::OP_B_BIT] &&
                  !d.ctrl1[rx_buf_pkg::OP_C_BIT];
    if (ctrlWrite && (q.mode != rx_buf_pkg::RX_IDLE))
    begin
      d.mode = rx_buf_pkg::RX_IDLE;
      d.count = '0;
      d.wptr = '0;
      d.rptr = '0;
      d.bitCnt = '0;
      d.center = 1'b0;
      d.irq = 1'b0;
      d.restart = restartCond;
    end

    // registered copy keeps the mode output straight off a flop
    d.active = (d.mode != rx_buf_pkg::RX_IDLE);
  end

  // one register bank for all state
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q <= '0;
      q.mode <= rx_buf_pkg::RX_IDLE;
      q.ctrl1 <= rx_buf_pkg::CTRL_RST;
      q.ctrl4 <= rx_buf_pkg::CTRL_RST;
      q.ctrl5 <= rx_buf_pkg::CTRL_RST;
      q.ctrl6 <= rx_buf_pkg::CTRL_RST;
      q.ctrl7 <= rx_buf_pkg::CTRL_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign regRdata = q.rdata;
  assign irqOut = q.irq;
  assign rxActive = q.active;
  assign restartSigProc = q.restart;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_ENTER_RX: assert property (q.mode == rx_buf_pkg::RX_IDLE && bitCheckDone &&
    !q.ctrl1[rx_buf_pkg::TRANSP_BIT] && !ctrlWrite |=> rxActive)
    else $error("no receiving mode after bit-check");
  AST_TRANSP_HOLD: assert property (q.mode == rx_buf_pkg::RX_IDLE &&
    q.ctrl1[rx_buf_pkg::TRANSP_BIT] && !regWr |=> !rxActive)
    else $error("buffering started in transparent mode");
  AST_TIMING_ERR: assert property (rxActive && edgeSeen && !isSingle && !isDouble &&
    !ctrlWrite |=> !rxActive && irqOut)
    else $error("bad gap not flagged");
  AST_LOGIC_ERR: assert property (q.mode == rx_buf_pkg::RX_DATA && edgeSeen && isDouble &&
    !q.center && !ctrlWrite |=> !rxActive && irqOut)
    else $error("missing mid-cell edge not flagged");
  AST_ERR_NO_STORE: assert property (bitErr |-> !push)
    else $error("errored byte stored");
  AST_COUNT_UP: assert property (push && !pop && !ctrlWrite &&
    q.count != rx_buf_pkg::CNT_FULL |=> q.count == $past(q.count) + rx_buf_pkg::CNT_ONE)
    else $error("counter missed a stored byte");
  AST_COUNT_SAT: assert property (push && !pop && !ctrlWrite &&
    q.count == rx_buf_pkg::CNT_FULL |=> q.count == rx_buf_pkg::CNT_FULL ##0 q.rptr == $past(q.rptr) + rx_buf_pkg::PTR_ONE)
    else $error("full buffer did not overwrite oldest");
  AST_COUNT_RANGE: assert property (q.count <= rx_buf_pkg::CNT_FULL)
    else $error("counter beyond buffer size");
  AST_READ_DATA: assert property (pop |=> regRdata == $past(memQ) &&
    q.count == $past(q.count) - rx_buf_pkg::CNT_ONE + {4'h0, $past(push)})
    else $error("read data or count wrong");
  AST_CTRL_WIPE: assert property (ctrlWrite && rxActive |=>
    q.count == '0 && !rxActive && !irqOut ##1 !rxActive || $past(bitCheckDone))
    else $error("control write did not reset buffer logic");
  AST_RESTART: assert property (ctrlWrite && rxActive |=> restartSigProc ==
    (q.ctrl1[rx_buf_pkg::OP_A_BIT] && q.ctrl1[rx_buf_pkg::OP_B_BIT] && !q.ctrl1[rx_buf_pkg::OP_C_BIT]))
    else $error("restart pulse disagrees with mode bits");

  COV_START_BIT: cover property (q.mode == rx_buf_pkg::RX_HUNT ##1 q.mode == rx_buf_pkg::RX_DATA);
  COV_BYTE_STORED: cover property (push && !bitErr);
  COV_OVERWRITE: cover property (push && q.count == rx_buf_pkg::CNT_FULL);
  COV_BIT_ERROR: cover property (bitErr && q.mode == rx_buf_pkg::RX_DATA);
endmodule
`default_nettype wire

// [manchester_source.sv]
// manchester stream source standing in for the remote transmitter
`timescale 1ns/1ns
`default_nettype none
module manchester_source #(
  parameter int HALF = 28 // mclk cycles per half bit
) (
  input wire logic mclk, // system clock
  output logic line // demodulated level toward the block
);
  // idle low; callers enter the tasks just after a rising edge
  initial line = 1'b0;

  // inverse level first, so the centre edge carries the bit
  task automatic sendBit(input logic b);
    line <= ~b;
    repeat (HALF) @(posedge mclk);
    line <= b;
    repeat (HALF) @(posedge mclk);
  endtask

  // all-zero preburst, so the start bit that follows is a one
  task automatic preburst(input int n);
    repeat (n) sendBit(1'b0);
  endtask

  // top nbits of a byte, most significant first
  task automatic sendByte(input logic [7:0] b, input int nbits);
    for (int i = 7; i > 7 - nbits; i--)
    begin
      sendBit(b[i]);
    end
  endtask

  // commanded fault only: boundary edge, then one gap of len cycles
  task automatic badGap(input int len);
    line <= ~line;
    repeat (len) @(posedge mclk);
    line <= ~line;
    repeat (8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// [rx_buffer_ctrl_bench.sv]
// self-checking bench for the receive buffer control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module rx_buffer_ctrl_bench;
  // --------------------------------
  // signals and tables
  // --------------------------------
  localparam int HALF = 42; // 21 ticks per half bit at a divide of two
  typedef struct {
    logic [1:0] sel;
    int nBytes;
    int expIrq;
    logic [4:0] expCnt;
  } row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic bitCheckDone = 1'b0;
  logic [7:0] regRdata;
  logic demodIn;
  logic irqOut;
  logic rxActive;
  logic restartSigProc;
  logic [7:0] rd;
  int fail_count = 0;
  int checked = 0;
  int irqCnt = 0;
  int restartCnt = 0;
  // last row runs past sixteen bytes
  row_t rows [5] = '{'{2'h0, 1, 2, 5'h01}, '{2'h1, 3, 1, 5'h03}, '{2'h2, 8, 2, 5'h08},
    '{2'h3, 12, 2, 5'h0C}, '{2'h3, 18, 2, 5'h10}};
  int gaps [3] = '{12, 66, 84};
  logic [3:0] wrAddr [5] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7};
  logic [7:0] wrData [5] = '{8'h03, 8'h00, 8'h0B, 8'h20, 8'h00};

  // 125 MHz
  always #4 mclk = ~mclk;

  rx_buffer_ctrl #(.TICK_DIV(2)) i_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .demodIn(demodIn), .bitCheckDone(bitCheckDone),
    .irqOut(irqOut), .rxActive(rxActive), .restartSigProc(restartSigProc));
  manchester_source #(.HALF(HALF)) i_src (.mclk(mclk), .line(demodIn));

  // one-cycle pulses are counted where they stand
  always @(posedge mclk)
  begin
    if (irqOut === 1'b1) irqCnt++;
    if (restartSigProc === 1'b1) restartCnt++;
  end

  // --------------------------------
  // tasks
  // --------------------------------
  function automatic logic [7:0] dataByte(input int k);
    return (k == 0) ? 8'hB4 : 8'(k * 37 + 3);
  endfunction

  // trailing idle edge keeps back-to-back strobes from colliding
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge mclk);
  endtask

  task automatic setup(input logic [7:0] c1);
    regWrite(rx_buf_pkg::CTRL5_IDX, 8'h0B);
    regWrite(rx_buf_pkg::CTRL6_IDX, 8'h20);
    regWrite(rx_buf_pkg::CTRL1_IDX, c1);
  endtask

  // bit-check success after six preburst bits, next to an edge
  task automatic startRx();
    fork
      i_src.preburst(12);
      begin
        repeat (12 * HALF + 4) @(posedge mclk);
        bitCheckDone <= 1'b1;
        @(posedge mclk);
        bitCheckDone <= 1'b0;
      end
    join
  endtask

  task automatic drain(input int off, input int n);
    for (int k = 0; k < n; k++)
    begin
      regRead(rx_buf_pkg::FIFO_IDX, rd);
      `CHK(rd, dataByte(off + k))
    end
    regRead(rx_buf_pkg::STAT_IDX, rd);
    `CHK(rd, 8'h00)
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------
  // sequence
  // --------------------------------
  // a hang is cut well past the expected run of about 55k cycles
  initial
  begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK({irqOut, rxActive, restartSigProc}, 3'b000)
    regRead(rx_buf_pkg::FIFO_IDX, rd);
    `CHK(rd, 8'h00)
    regWrite(4'hF, 8'hFF);
    regRead(4'hF, rd);
    `CHK(rd, 8'h00)
    // fill levels and overflow; every frame ends by timeout
    foreach (rows[i])
    begin
      setup({2'b00, rows[i].sel, 4'h0});
      irqCnt = 0;
      startRx();
      `CHK(rxActive, 1'b1)
      for (int k = 0; k < rows[i].nBytes; k++)
      begin
        i_src.sendByte(dataByte(k), 8);
      end
      repeat (120) @(posedge mclk);
      `CHK(rxActive, 1'b0)
      `CHK(irqCnt, rows[i].expIrq)
      regRead(rx_buf_pkg::STAT_IDX, rd);
      `CHK(rd, {3'b000, rows[i].expCnt})
      drain(rows[i].nBytes - int'(rows[i].expCnt), int'(rows[i].expCnt));
    end
    // gap too short, between windows, double after a boundary edge
    foreach (gaps[g])
    begin
      setup(8'h00);
      irqCnt = 0;
      startRx();
      i_src.sendByte(dataByte(0), 8);
      i_src.sendByte(8'hE0, 3);
      i_src.badGap(gaps[g]);
      `CHK(rxActive, 1'b0)
      `CHK(irqCnt, 2)
      regRead(rx_buf_pkg::STAT_IDX, rd);
      `CHK(rd, 8'h01)
      drain(0, 1);
    end
    // control writes mid-reception; restart only with mode bits 011
    foreach (wrAddr[w])
    begin
      setup((w % 2 == 0) ? 8'h03 : 8'h00);
      restartCnt = 0;
      startRx();
      i_src.sendByte(dataByte(0), 8);
      i_src.sendByte(dataByte(1), 8);
      regRead(rx_buf_pkg::STAT_IDX, rd);
      `CHK(rd, 8'h82)
      regWrite(wrAddr[w], wrData[w]);
      repeat (2) @(posedge mclk);
      `CHK(restartCnt, (w % 2 == 0) ? 1 : 0)
      `CHK(rxActive, 1'b0)
      regRead(rx_buf_pkg::STAT_IDX, rd);
      `CHK(rd, 8'h00)
    end
    // reset in mid-frame clears mode, count and limits
    setup(8'h00);
    startRx();
    i_src.sendByte(dataByte(0), 8);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK({irqOut, rxActive, restartSigProc}, 3'b000)
    regRead(rx_buf_pkg::STAT_IDX, rd);
    `CHK(rd, 8'h00)
    regRead(rx_buf_pkg::CTRL5_IDX, rd);
    `CHK(rd, 8'h00)
    // transparent mode keeps the buffer out of the path
    setup(8'h08);
    startRx();
    `CHK(rxActive, 1'b0)
    print_verdict();
  end
endmodule
`default_nettype wire
